// ---- flash_write_guard_and_access_status.sv ----
// write guard register, access status register and operation gating
`timescale 1ns/10ps
module flash_write_guard_and_access_status (
   input  wire logic                                 clk,              // 40 MHz clock
   input  wire logic                                 reset,            // sync, active high
   input  wire logic [flash_guard_pkg::ADDR_W-1:0]   regAddr,          // register address
   input  wire logic                                 regWrite,         // write strobe
   input  wire logic                                 regRead,          // read strobe
   input  wire logic [flash_guard_pkg::DATA_W-1:0]   regWdata,         // write data
   output logic      [flash_guard_pkg::DATA_W-1:0]   regRdata,         // read data
   output logic                                      regAck,           // access done
   input  wire logic [flash_guard_pkg::OP_KINDS-1:0] opRequest,        // op start requests
   output logic      [flash_guard_pkg::OP_KINDS-1:0] opGrant,          // ops let through
   output logic                                      guardPermits,     // guard field is 01
   input  wire logic [flash_guard_pkg::RST_SOURCES-1:0] guardResetSrc, // async reset sources
   input  wire logic                                 correctedEvent,   // 1-bit error fixed
   input  wire logic                                 dataViolEvent,    // data flash violation
   input  wire logic                                 codeViolEvent,    // code flash violation
   input  wire logic                                 lockEvent,        // other sequencer error
   input  wire logic                                 statusClearStart, // status clear begins
   input  wire logic                                 forcedStopStart,  // forced stop begins
   input  wire logic                                 forcedCorrFlag,   // correction flag of fsm
   output logic                                      commandLocked     // locked state
);
   // guard reset sources: external_reset_pin, power-on, three voltage monitors,
   // two watchdogs, software reset, software standby and deep software standby
   logic [flash_guard_pkg::RST_SOURCES-1:0] resetSrcSync;
   logic [1:0]                              guard_q;
   logic [1:0]                              guard_d;
   logic                                    corr_q;
   logic                                    corr_d;
   logic                                    dataViol_q;
   logic                                    dataViol_d;
   logic                                    codeViol_q;
   logic                                    codeViol_d;
   logic                                    lock_q;
   logic                                    lock_d;
   logic                                    dataArmed_q;
   logic                                    dataArmed_d;
   logic                                    codeArmed_q;
   logic                                    codeArmed_d;
   logic [flash_guard_pkg::DATA_W-1:0]      rdata_q;
   logic [flash_guard_pkg::DATA_W-1:0]      rdata_d;
   logic                                    ack_q;
   logic [flash_guard_pkg::OP_KINDS-1:0]    grant_q;
   logic                                    permit_q;
   logic                                    locked_q;

   flash_level_sync #(
      .WIDTH    (flash_guard_pkg::RST_SOURCES)
   ) u_reset_sync (
      .clk      (clk),
      .reset    (reset),
      .levelIn  (guardResetSrc),
      .levelOut (resetSrcSync)
   );

   // address decoding
   wire hitGuard    = (regAddr == flash_guard_pkg::GUARD_OFFSET);
   wire hitStatus   = (regAddr == flash_guard_pkg::STATUS_OFFSET);
   wire wrGuard     = regWrite & hitGuard;
   wire wrStatus    = regWrite & hitStatus;
   wire rdStatus    = regRead & hitStatus;
   wire guardReinit = |resetSrcSync;

   // status image with reserved bits tied low
   wire [7:0] statusImage = {codeViol_q,
                             2'b00,
                             lock_q,
                             dataViol_q,
                             2'b00,
                             corr_q};
   wire [7:0] guardImage  = {6'h00, guard_q};

   // a 0 written to a violation flag counts only once it was read as 1
   wire clrData = wrStatus & ~regWdata[flash_guard_pkg::DATA_VIOL_BIT] & dataArmed_q;
   wire clrCode = wrStatus & ~regWdata[flash_guard_pkg::CODE_VIOL_BIT] & codeArmed_q;
   wire cmdStart    = statusClearStart | forcedStopStart;
   wire clrCorr     = forcedStopStart & forcedCorrFlag;
   wire violsClear  = ~dataViol_q & ~codeViol_q;
   wire setLock     = lockEvent | dataViolEvent | codeViolEvent;
   wire clrLock     = cmdStart & violsClear;

   // guard field next value; any reset source forces the reset pattern
   always_comb begin
      guard_d = guard_q;
      if (guardReinit) begin
         guard_d = flash_guard_pkg::GUARD_RESET;
      end else if (wrGuard) begin
         guard_d = regWdata[flash_guard_pkg::GUARD_MSB:flash_guard_pkg::GUARD_LSB];
      end
   end

   // correction flag: set beats clear so no event is lost
   always_comb begin
      corr_d = corr_q;
      if (correctedEvent) begin
         corr_d = 1'b1;
      end else if (clrCorr) begin
         corr_d = 1'b0;
      end
   end

   // violation flags: sticky, set wins over a simultaneous software clear
   always_comb begin
      dataViol_d = dataViol_q;
      codeViol_d = codeViol_q;
      if (dataViolEvent) begin
         dataViol_d = 1'b1;
      end else if (clrData) begin
         dataViol_d = 1'b0;
      end
      if (codeViolEvent) begin
         codeViol_d = 1'b1;
      end else if (clrCode) begin
         codeViol_d = 1'b0;
      end
   end

   // read-before-clear tracking; a clear or a new flag disarms it
   always_comb begin
      dataArmed_d = dataArmed_q;
      codeArmed_d = codeArmed_q;
      if (dataViolEvent | clrData) begin
         dataArmed_d = 1'b0;
      end else if (rdStatus & dataViol_q) begin
         dataArmed_d = 1'b1;
      end
      if (codeViolEvent | clrCode) begin
         codeArmed_d = 1'b0;
      end else if (rdStatus & codeViol_q) begin
         codeArmed_d = 1'b1;
      end
   end

   // lock flag: entering the locked state beats a release in the same cycle
   always_comb begin
      lock_d = lock_q;
      if (setLock) begin
         lock_d = 1'b1;
      end else if (clrLock) begin
         lock_d = 1'b0;
      end
   end

   // read data mux; unmapped addresses read zero
   always_comb begin
      rdata_d = '0;
      if (regRead & hitGuard) begin
         rdata_d = guardImage;
      end else if (rdStatus) begin
         rdata_d = statusImage;
      end
   end

   // permission decode: only the single 01 pattern lets work through
   wire permitNow = (guard_q == flash_guard_pkg::GUARD_PERMIT);
   wire [flash_guard_pkg::OP_KINDS-1:0] grantNow =
      opRequest & {flash_guard_pkg::OP_KINDS{permitNow}};

   // guard register
   always_ff @(posedge clk) begin
      if (reset) begin
         guard_q <= flash_guard_pkg::GUARD_RESET;
      end else begin
         guard_q <= guard_d;
      end
   end

   // status flags
   always_ff @(posedge clk) begin
      if (reset) begin
         corr_q     <= flash_guard_pkg::STATUS_RESET[flash_guard_pkg::CORR_BIT];
         dataViol_q <= flash_guard_pkg::STATUS_RESET[flash_guard_pkg::DATA_VIOL_BIT];
         codeViol_q <= flash_guard_pkg::STATUS_RESET[flash_guard_pkg::CODE_VIOL_BIT];
         lock_q     <= flash_guard_pkg::STATUS_RESET[flash_guard_pkg::LOCK_BIT];
      end else begin
         corr_q     <= corr_d;
         dataViol_q <= dataViol_d;
         codeViol_q <= codeViol_d;
         lock_q     <= lock_d;
      end
   end

   // read-before-clear arming
   always_ff @(posedge clk) begin
      if (reset) begin
         dataArmed_q <= 1'b0;
         codeArmed_q <= 1'b0;
      end else begin
         dataArmed_q <= dataArmed_d;
         codeArmed_q <= codeArmed_d;
      end
   end

   // bus answer, one cycle after the strobe
   always_ff @(posedge clk) begin
      if (reset) begin
         rdata_q <= '0;
         ack_q   <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         ack_q   <= regRead | regWrite;
      end
   end

   // registered outputs; grants lag the request by one cycle, which keeps
   // the gate glitch-free at the cost of a cycle of start latency
   always_ff @(posedge clk) begin
      if (reset) begin
         grant_q  <= '0;
         permit_q <= 1'b0;
         locked_q <= 1'b0;
      end else begin
         grant_q  <= grantNow;
         permit_q <= permitNow;
         locked_q <= lock_d;
      end
   end

   assign regRdata      = rdata_q;
   assign regAck        = ack_q;
   assign opGrant       = grant_q;
   assign guardPermits  = permit_q;
   assign commandLocked = locked_q;
endmodule : flash_write_guard_and_access_status

// ---- flash_guard_pkg.sv ----
// constants for the flash write guard and access status block
// What this block does
// - program, erase and blank check are blocked unless the guard field holds 01
// - guard register bits 7 to 2 read zero; software writes zero there
// - guard register returns to reset value on every listed reset and standby entry
// - status bit 3 reads 1 after a data flash access violation
// - status bit 4 reads 1 while the sequencer is command locked
// - status bit 7 reads 1 after a code flash access violation
// - status bits 2:1 and 6:5 read zero; software writes zero there
// - violation flag clears only on a 0 written after reading 1
// - code violation, data violation or lock set puts sequencer in locked state
// - correction flag sets on a corrected single-bit error in sequencer reads
// - lock flag clears on status clear or forced stop start with violations zero
package flash_guard_pkg;
   localparam int          ADDR_W            = 24;
   localparam int          DATA_W            = 8;
   localparam logic [23:0] GUARD_OFFSET      = 24'h08C296;
   localparam logic [23:0] STATUS_OFFSET     = 24'h7FE010;
   // guard register field
   localparam int          GUARD_LSB         = 0;
   localparam int          GUARD_MSB         = 1;
   localparam logic [1:0]  GUARD_RESET       = 2'h2;
   localparam logic [1:0]  GUARD_PERMIT      = 2'h1;
   // status register bit positions
   localparam int          CORR_BIT          = 0;
   localparam int          DATA_VIOL_BIT     = 3;
   localparam int          LOCK_BIT          = 4;
   localparam int          CODE_VIOL_BIT     = 7;
   localparam logic [7:0]  STATUS_RESET      = 8'h00;
   // operation kinds gated by the guard
   localparam int          OP_CODE_FLASH     = 0;
   localparam int          OP_DATA_FLASH     = 1;
   localparam int          OP_OPTION_MEM     = 2;
   localparam int          OP_LOCK_BITS      = 3;
   localparam int          OP_BLANK_CHECK    = 4;
   localparam int          OP_KINDS          = 5;
   // reset and standby sources of the guard register
   localparam int          RST_SOURCES       = 10;
   localparam int          SYNC_STAGES       = 2;
endpackage : flash_guard_pkg

// ---- flash_level_sync.sv ----
// two-flop synchroniser for a group of level inputs
`timescale 1ns/10ps
module flash_level_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,      // block clock
   input  wire logic             reset,    // synchronous, active high
   input  wire logic [WIDTH-1:0] levelIn,  // asynchronous levels
   output logic      [WIDTH-1:0] levelOut  // levels in the clock domain
);
   logic [WIDTH-1:0] stage1_q;
   logic [WIDTH-1:0] stage2_q;

   // first stage feeds only the second stage, to keep metastability contained
   always_ff @(posedge clk) begin
      if (reset) begin
         stage1_q <= '0;
         stage2_q <= '0;
      end else begin
         stage1_q <= levelIn;
         stage2_q <= stage1_q;
      end
   end

   assign levelOut = stage2_q;
endmodule : flash_level_sync

// ---- flash_guard_chk.sv ----
// port checker for the write guard and access status block
`timescale 1ns/10ps
module flash_guard_chk (
   input wire logic                                    clk,              // block clock
   input wire logic                                    reset,            // sync, active high
   input wire logic                                    regRead,          // read strobe
   input wire logic                                    regWrite,         // write strobe
   input wire logic                                    regAck,           // access done
   input wire logic                                    guardPermits,     // guard field is 01
   input wire logic                                    commandLocked,    // locked state
   input wire logic                                    statusClearStart, // status clear begins
   input wire logic                                    forcedStopStart,  // forced stop begins
   input wire logic                                    dataViolEvent,    // data violation
   input wire logic                                    codeViolEvent,    // code violation
   input wire logic                                    lockEvent,        // other error
   input wire logic [flash_guard_pkg::ADDR_W-1:0]      regAddr,          // register address
   input wire logic [flash_guard_pkg::DATA_W-1:0]      regRdata,         // read data
   input wire logic [flash_guard_pkg::OP_KINDS-1:0]    opRequest,        // op start requests
   input wire logic [flash_guard_pkg::OP_KINDS-1:0]    opGrant,          // ops let through
   input wire logic [flash_guard_pkg::RST_SOURCES-1:0] guardResetSrc     // async sources
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // read decodes; anything else counts as unmapped
   wire gRd = regRead && regAddr == flash_guard_pkg::GUARD_OFFSET;
   wire sRd = regRead && regAddr == flash_guard_pkg::STATUS_OFFSET;
   wire uRd = regRead && !gRd && !sRd;
   property p_ack; regAck == $past(regRead || regWrite); endproperty
   a_ack: assert property (p_ack) else $error("ack not one cycle after strobe");
   property p_grant; opGrant == ($past(opRequest) & {5{guardPermits}}); endproperty
   a_grant: assert property (p_grant) else $error("grant not gated by guard");
   property p_grd; gRd |=> regRdata[7:2] == 6'h00 && (regRdata[1:0] == 2'h1) == guardPermits;
   endproperty
   a_grd: assert property (p_grd) else $error("guard read wrong");
   property p_srd; sRd |=> {regRdata[6:5], regRdata[2:1]} == 4'h0
      && regRdata[4] == $past(commandLocked); endproperty
   a_srd: assert property (p_srd) else $error("status read wrong");
   property p_urd; uRd |=> regRdata == 8'h00; endproperty
   a_urd: assert property (p_urd) else $error("unmapped read not zero");
   property p_set; codeViolEvent || dataViolEvent |=> commandLocked; endproperty
   a_set: assert property (p_set) else $error("violation did not lock");
   property p_rise; $rose(commandLocked) |-> $past(codeViolEvent || dataViolEvent || lockEvent);
   endproperty
   a_rise: assert property (p_rise) else $error("lock without cause");
   property p_fell; $fell(commandLocked) |-> $past(statusClearStart || forcedStopStart);
   endproperty
   a_fell: assert property (p_fell) else $error("lock left without command");
   property p_hold; commandLocked && !statusClearStart && !forcedStopStart |=> commandLocked;
   endproperty
   a_hold: assert property (p_hold) else $error("lock not held");
   // two synchroniser edges, one guard edge and one permit edge before the output drops
   property p_src; (guardResetSrc != '0) [*5] |-> !guardPermits; endproperty
   a_src: assert property (p_src) else $error("guard permits under reset source");
endmodule : flash_guard_chk
bind flash_write_guard_and_access_status flash_guard_chk chk (.clk, .reset, .regRead,
   .regWrite, .regAck, .guardPermits, .commandLocked, .statusClearStart, .forcedStopStart,
   .dataViolEvent, .codeViolEvent, .lockEvent, .regAddr, .regRdata, .opRequest, .opGrant,
   .guardResetSrc);

// ---- flash_write_guard_and_access_status_tb.sv ----
// self-checking bench of the write guard and access status block
`timescale 1ns/10ps
module flash_write_guard_and_access_status_tb;
   logic        clk, reset, regWrite, regRead, regAck, guardPermits, commandLocked;
   logic [23:0] regAddr, gA, sA;
   logic [7:0]  regWdata, regRdata, rv, d;
   logic [4:0]  opRequest, opGrant;
   logic [9:0]  src;
   logic [6:0]  ev;
   int          errorCnt, nCompared, seed, i;
   // ev: corr, data, code, lock, status clear, forced stop, forced corr level
   flash_write_guard_and_access_status uut (.clk, .reset, .regAddr, .regWrite, .regRead,
      .regWdata, .regRdata, .regAck, .opRequest, .opGrant, .guardPermits,
      .guardResetSrc(src), .correctedEvent(ev[0]), .dataViolEvent(ev[1]),
      .codeViolEvent(ev[2]), .lockEvent(ev[3]), .statusClearStart(ev[4]),
      .forcedStopStart(ev[5]), .forcedCorrFlag(ev[6]), .commandLocked);
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // expected guard read and gate output, worked out from the field value and the request
   function automatic logic [7:0] expGuard(input logic [7:0] wd);
      return {6'h00, wd[flash_guard_pkg::GUARD_MSB:flash_guard_pkg::GUARD_LSB]};
   endfunction : expGuard
   function automatic logic [7:0] expGrant(input logic [1:0] fld, input logic [4:0] req);
      return (fld == flash_guard_pkg::GUARD_PERMIT) ? {3'h0, req} : 8'h00;
   endfunction : expGrant
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      nCompared++;
      if (seen !== exp) begin
         errorCnt++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk
   // inputs move 2 ns after the edge so the design never races the bench
   task step(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : step
   // one register access; read data is taken in the cycle the ack stands
   task acc(input logic w, input logic [23:0] a, input logic [7:0] wd);
      step(1);
      regWrite = w;
      regRead = !w;
      regAddr = a;
      regWdata = wd;
      step(1);
      rv = regRdata;
      regWrite = 1'b0;
      regRead = 1'b0;
   endtask : acc
   task rc(input logic [23:0] a, input logic [7:0] exp);
      acc(1'b0, a, 8'h00);
      chk(rv, exp);
   endtask : rc
   task pulse(input int k);
      step(1);
      ev[k] = 1'b1;
      step(1);
      ev[k] = 1'b0;
   endtask : pulse
   task completeRun;
      $display("compared %0d, mismatches %0d", nCompared, errorCnt);
      if (errorCnt == 0 && nCompared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : completeRun
   // watchdog: the tests need a few hundred cycles
   initial begin
      step(3000);
      errorCnt++;
      $display("Error at %0t: watchdog ran out", $time);
      completeRun();
   end
   initial begin
      seed = 32'h9943081E;
      {regWrite, regRead, regAddr, regWdata, opRequest, src, ev} = '0;
      gA = flash_guard_pkg::GUARD_OFFSET;
      sA = flash_guard_pkg::STATUS_OFFSET;
      errorCnt = 0;
      nCompared = 0;
      reset = 1'b1;
      step(8);
      reset = 1'b0;
      opRequest = 5'h1F;
      rc(gA, 8'h02);
      rc(sA, 8'h00);
      chk({3'h0, opGrant}, 8'h00);
      $display("reset values done");
      // every field value once, then random ones; software keeps bits 7 to 2 at zero
      for (i = 0; i < 8; i++) begin
         d = {6'h00, 2'($random(seed))};
         if (i < 4) d[1:0] = i[1:0];
         opRequest = 5'($random(seed));
         acc(1'b1, gA, d);
         rc(gA, expGuard(d));
         chk({3'h0, opGrant}, expGrant(d[1:0], opRequest));
         chk({7'h00, guardPermits}, expGrant(d[1:0], 5'h01));
      end
      acc(1'b1, gA + 24'h000001, 8'h01);
      rc(gA, expGuard(d));
      rc({1'b1, 23'($random(seed))}, 8'h00);
      $display("guard field and gate done");
      // each source alone; a write made while it is held must be ignored
      for (i = 0; i < 10; i++) begin
         acc(1'b1, gA, 8'h01);
         src[i] = 1'b1;
         step(4);
         acc(1'b1, gA, 8'h01);
         rc(gA, 8'h02);
         src[i] = 1'b0;
         step(3);
      end
      $display("guard reset sources done");
      // a zero written before any read of 1 must not clear
      pulse(2);
      pulse(1);
      acc(1'b1, sA, 8'h00);
      rc(sA, 8'h98);
      chk({7'h00, commandLocked}, 8'h01);
      pulse(4);
      acc(1'b1, sA, 8'h88); // ones on the flag bits must do nothing
      rc(sA, 8'h98);
      acc(1'b1, sA, 8'h00);
      rc(sA, 8'h10);
      pulse(4); // flags cleared first, then status clear
      rc(sA, 8'h00);
      pulse(3);
      rc(sA, 8'h10);
      pulse(5);
      rc(sA, 8'h00);
      $display("violation and lock done");
      pulse(0);
      acc(1'b1, sA, 8'h00);
      rc(sA, 8'h01);
      ev[6] = 1'b1;
      pulse(5);
      ev[6] = 1'b0;
      rc(sA, 8'h00);
      $display("correction flag done");
      // guard open and flags set, then a reset in mid-run must restore reset values
      acc(1'b1, gA, 8'h01);
      pulse(0);
      pulse(2);
      reset = 1'b1;
      step(2);
      reset = 1'b0;
      rc(sA, flash_guard_pkg::STATUS_RESET);
      rc(gA, {6'h00, flash_guard_pkg::GUARD_RESET});
      chk({3'h0, opGrant}, 8'h00);
      chk({7'h00, commandLocked}, 8'h00);
      $display("reset in mid-run done");
      completeRun();
   end
endmodule : flash_write_guard_and_access_status_tb
